//--- src/rtc_cfg_alarm_trim.sv
/*
  configuration registers, alarm flag and shared output pin logic,
  oscillator divider with digital trim, write guard and power policy.
  assumes the serial bus engine presents decoded byte accesses on the
  register port, the alarm comparators give one-cycle match pulses and
  the oscillator level arrives synchronous to clock.
*/
// Overview of operation
// R1 - guarded eeprom writes are silently dropped
// R2 - guard field decodes six protected partitions
// R3 - alarms drive pin only with enable, clkout off
// R4 - pulsed mode pulses pin on every match
// R5 - both enabled alarms each signal the pin
// R6 - clkout select gives alarm, 32k, 4096, 1Hz
// R7 - active clock output suppresses alarm signalling
// R8 - six bit analog trim sets pin capacitance
// R9 - digital trim alters counts per second
// R10 - top digital trim bit is sign
// R11 - trim weights 10 and 20 ppm summed
// R12 - bus disabled in backup when bit set
// R13 - policy bit picks standard or legacy switching
// R14 - threshold field decodes five reset voltages
// R15 - alarm flag set on match regardless enable
// R16 - single event holds pin low until read
// R17 - pulsed interrupt is fixed length low pulse
`default_nettype none

module rtc_cfg_alarm_trim #(
  parameter logic [7:0] PWR_RESET = rtc_cfg_pkg::RST_PWR  // variant strap
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,              // register address
  input  wire logic        reg_wr,                // write strobe
  input  wire logic [7:0]  reg_wdata,             // write byte
  input  wire logic        reg_rd,                // read strobe
  output logic      [7:0]  reg_rdata,             // read byte
  input  wire logic [8:0]  ee_addr,               // eeprom write target
  input  wire logic        ee_wr_req,             // eeprom write request
  output logic             ee_wr_go,              // write allowed
  input  wire logic        alarm0_match,          // alarm 0 match pulse
  input  wire logic        alarm1_match,          // alarm 1 match pulse
  output logic             alarm0_flag,           // sticky alarm 0
  output logic             alarm1_flag,           // sticky alarm 1
  input  wire logic        osc_32k,               // oscillator level
  output logic             alarm_or_clock_out_n,  // shared output pin
  output logic      [6:0]  cx_half_pf,            // pin capacitance
  output logic signed [5:0] trim_ppm,             // digital trim value
  output logic             sec_tick,              // trimmed second
  input  wire logic        on_backup,             // backup supply active
  output logic             bus_enable,            // serial bus enable
  output logic             supply_switch_policy,  // 1 legacy, 0 standard
  output logic      [12:0] reset_threshold_mv     // reset trip level
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0]           write_guard_cfg_r;     // guard and watchdog
  logic [7:0]           alarm_irq_clkout_cfg_r;// irq enables, clkout
  logic [7:0]           analog_trim_cfg_r;     // analog trim code
  logic [7:0]           digital_trim_cfg_r;    // digital trim code
  logic [7:0]           power_switch_cfg_r;    // power policy
  logic                 alarm0_flag_r;         // sticky flags
  logic                 alarm1_flag_r;
  logic [7:0]           reg_rdata_r;           // registered read data

  // write strobes per register, status read strobe
  wire wr_guard = reg_wr && (reg_addr == rtc_cfg_pkg::ADDR_GUARD);
  wire wr_irq   = reg_wr && (reg_addr == rtc_cfg_pkg::ADDR_IRQ);
  wire wr_atrim = reg_wr && (reg_addr == rtc_cfg_pkg::ADDR_ATRIM);
  wire wr_dtrim = reg_wr && (reg_addr == rtc_cfg_pkg::ADDR_DTRIM);
  wire wr_pwr   = reg_wr && (reg_addr == rtc_cfg_pkg::ADDR_PWR);
  wire sr_read  = reg_rd && (reg_addr == rtc_cfg_pkg::ADDR_STATUS);

  // field views
  wire [2:0] write_guard_field = write_guard_cfg_r[rtc_cfg_pkg::GUARD_LSB +: 3];
  wire       pulsed_alarm_select = alarm_irq_clkout_cfg_r[rtc_cfg_pkg::IM_BIT];
  wire       alarm1_irq_on = alarm_irq_clkout_cfg_r[rtc_cfg_pkg::ALARM1_IRQ_ON_BIT];
  wire       alarm0_irq_on = alarm_irq_clkout_cfg_r[rtc_cfg_pkg::ALARM0_IRQ_ON_BIT];
  wire [1:0] clk_out_sel   = alarm_irq_clkout_cfg_r[rtc_cfg_pkg::FO_LSB +: 2];
  wire       bus_off_in_backup = power_switch_cfg_r[rtc_cfg_pkg::BUS_OFF_IN_BACKUP_BIT];

  // register writes keep reserved bits at zero
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      write_guard_cfg_r      <= rtc_cfg_pkg::RST_GUARD;
      alarm_irq_clkout_cfg_r <= rtc_cfg_pkg::RST_IRQ;
      analog_trim_cfg_r      <= rtc_cfg_pkg::RST_ATRIM;
      digital_trim_cfg_r     <= rtc_cfg_pkg::RST_DTRIM;
      power_switch_cfg_r     <= PWR_RESET & rtc_cfg_pkg::MASK_PWR;
    end
    else
    begin
      if (wr_guard) write_guard_cfg_r <= reg_wdata & rtc_cfg_pkg::MASK_GUARD;
      if (wr_irq)   alarm_irq_clkout_cfg_r <= reg_wdata & rtc_cfg_pkg::MASK_IRQ;
      if (wr_atrim) analog_trim_cfg_r <= reg_wdata & rtc_cfg_pkg::MASK_ATRIM;
      if (wr_dtrim) digital_trim_cfg_r <= reg_wdata & rtc_cfg_pkg::MASK_DTRIM;
      if (wr_pwr)   power_switch_cfg_r <= reg_wdata & rtc_cfg_pkg::MASK_PWR;
    end
  end

  // ----------------------------------------------------------------
  // read mux and alarm flags
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;   // selected read byte, unmapped reads zero
  always_comb
  begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      rtc_cfg_pkg::ADDR_GUARD:  rd_mux = write_guard_cfg_r;
      rtc_cfg_pkg::ADDR_IRQ:    rd_mux = alarm_irq_clkout_cfg_r;
      rtc_cfg_pkg::ADDR_ATRIM:  rd_mux = analog_trim_cfg_r;
      rtc_cfg_pkg::ADDR_DTRIM:  rd_mux = digital_trim_cfg_r;
      rtc_cfg_pkg::ADDR_PWR:    rd_mux = power_switch_cfg_r;
      rtc_cfg_pkg::ADDR_STATUS:
      begin
        rd_mux[rtc_cfg_pkg::SR_AL1_BIT] = alarm1_flag_r;
        rd_mux[rtc_cfg_pkg::SR_AL0_BIT] = alarm0_flag_r;
      end
      default:                  rd_mux = 8'h00;
    endcase
  end

  // flags set on any match, cleared by status read, set wins
  wire alarm0_flag_nxt = alarm0_match | (alarm0_flag_r & ~sr_read);  // R15 R16
  wire alarm1_flag_nxt = alarm1_match | (alarm1_flag_r & ~sr_read);  // R15 R16

  // read data and flag update
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      reg_rdata_r   <= 8'h00;
      alarm0_flag_r <= 1'b0;
      alarm1_flag_r <= 1'b0;
    end
    else
    begin
      if (reg_rd) reg_rdata_r <= rd_mux;
      alarm0_flag_r <= alarm0_flag_nxt;
      alarm1_flag_r <= alarm1_flag_nxt;
    end
  end

  // ----------------------------------------------------------------
  // eeprom write guard
  // ----------------------------------------------------------------
  // true when addr falls in the partition the field protects
  function automatic logic guard_hit(input logic [2:0] fld, input logic [8:0] a);
    unique case (fld)
      3'h0:    guard_hit = 1'b0;                              // R2
      3'h1:    guard_hit = (a >= rtc_cfg_pkg::EE_UPPER_Q);    // R2
      3'h2:    guard_hit = (a >= rtc_cfg_pkg::EE_UPPER_H);    // R2
      3'h4:    guard_hit = (a <= rtc_cfg_pkg::EE_FIRST_4P);   // R2
      3'h5:    guard_hit = (a <= rtc_cfg_pkg::EE_FIRST_8P);   // R2
      3'h6:    guard_hit = (a <= rtc_cfg_pkg::EE_FIRST_16P);  // R2
      default: guard_hit = 1'b1;                              // R2
    endcase
  endfunction

  wire ee_blocked = guard_hit(write_guard_field, ee_addr);
  assign ee_wr_go = ee_wr_req & ~ee_blocked;  // R1

  // ----------------------------------------------------------------
  // oscillator divider with digital trim
  // ----------------------------------------------------------------
  logic [rtc_cfg_pkg::DIV_W-1:0] div_r;       // oscillator count
  logic                          osc_q_r;     // last oscillator level
  logic [20:0]                   trim_acc_r;  // ppm-count accumulator
  logic                          add_pend_r;  // one extra count owed
  logic                          skip_pend_r; // one count to drop
  logic                          sec_tick_r;

  wire       osc_rise = osc_32k & ~osc_q_r;
  wire       dt_sign  = digital_trim_cfg_r[rtc_cfg_pkg::DT_SIGN_BIT];      // R10
  wire [5:0] dt_mag   = (digital_trim_cfg_r[rtc_cfg_pkg::DT_10_BIT] ?
                         rtc_cfg_pkg::PPM_STEP_10 : 6'd0) +
                        (digital_trim_cfg_r[rtc_cfg_pkg::DT_20_BIT] ?
                         rtc_cfg_pkg::PPM_STEP_20 : 6'd0);                 // R11
  wire [1:0] div_step = skip_pend_r ? 2'd0 : (add_pend_r ? 2'd2 : 2'd1);   // R9
  wire [rtc_cfg_pkg::DIV_W:0] div_sum = {1'b0, div_r} +
                                        {{(rtc_cfg_pkg::DIV_W-1){1'b0}}, div_step};
  wire       sec_nxt  = osc_rise & div_sum[rtc_cfg_pkg::DIV_W];
  wire [20:0] acc_sum = trim_acc_r + 21'(dt_mag * rtc_cfg_pkg::OSC_HZ);
  wire       acc_ovf  = (acc_sum >= rtc_cfg_pkg::PPM_DEN) && (dt_mag != 6'd0);

  // each second adds ppm*32768 micro-counts; a whole count is then
  // added or dropped so the averaged error is corrected
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      div_r       <= '0;
      osc_q_r     <= 1'b0;
      trim_acc_r  <= 21'd0;
      add_pend_r  <= 1'b0;
      skip_pend_r <= 1'b0;
      sec_tick_r  <= 1'b0;
    end
    else
    begin
      osc_q_r    <= osc_32k;
      sec_tick_r <= sec_nxt;
      if (osc_rise)
      begin
        div_r <= div_sum[rtc_cfg_pkg::DIV_W-1:0];                          // R9
        if (div_step != 2'd1)
        begin
          add_pend_r  <= 1'b0;
          skip_pend_r <= 1'b0;
        end
      end
      if (sec_nxt)
      begin
        trim_acc_r <= acc_ovf ? acc_sum - rtc_cfg_pkg::PPM_DEN : acc_sum;  // R9
        if (acc_ovf && !dt_sign) add_pend_r  <= 1'b1;                      // R10
        if (acc_ovf && dt_sign)  skip_pend_r <= 1'b1;                      // R10
      end
    end
  end

  assign sec_tick = sec_tick_r;
  assign trim_ppm = dt_sign ? -$signed(dt_mag) : $signed(dt_mag);          // R10 R11

  // ----------------------------------------------------------------
  // shared alarm / clock output pin
  // ----------------------------------------------------------------
  logic [rtc_cfg_pkg::PULSE_W-1:0] pulse_cnt_r;  // pulse time left
  logic                            pin_n_r;      // registered pin level

  wire alarm_route = (clk_out_sel == rtc_cfg_pkg::CLKSEL_ALARM);           // R3 R7
  wire any_irq_on  = alarm0_irq_on | alarm1_irq_on;
  wire single_low  = alarm_route & ~pulsed_alarm_select &
                     ((alarm0_flag_r & alarm0_irq_on) |
                      (alarm1_flag_r & alarm1_irq_on));                    // R3 R5 R16
  wire pulse_start = alarm_route & pulsed_alarm_select &
                     ((alarm0_match & alarm0_irq_on) |
                      (alarm1_match & alarm1_irq_on));                     // R4 R5
  wire pulse_keep  = alarm_route & pulsed_alarm_select & any_irq_on;
  wire pulse_on    = (pulse_cnt_r != '0) & pulse_keep;

  // pin level for each clock output selection
  logic pin_n_nxt;
  always_comb
  begin
    pin_n_nxt = 1'b1;
    unique case (clk_out_sel)
      rtc_cfg_pkg::CLKSEL_ALARM: pin_n_nxt = ~(single_low | pulse_on);     // R3
      rtc_cfg_pkg::CLKSEL_32K:   pin_n_nxt = osc_q_r;                      // R6 R7
      rtc_cfg_pkg::CLKSEL_4096:  pin_n_nxt = div_r[rtc_cfg_pkg::DIV_4096_BIT]; // R6
      rtc_cfg_pkg::CLKSEL_1HZ:   pin_n_nxt = div_r[rtc_cfg_pkg::DIV_1HZ_BIT];  // R6
    endcase
  end

  // pulse timer restarts on each match, stops when mode is left
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pulse_cnt_r <= '0;
      pin_n_r     <= 1'b1;
    end
    else
    begin
      if (pulse_start)
        pulse_cnt_r <= rtc_cfg_pkg::PULSE_W'(rtc_cfg_pkg::PULSE_CYC);      // R17
      else if (!pulse_keep)
        pulse_cnt_r <= '0;
      else if (pulse_cnt_r != '0)
        pulse_cnt_r <= pulse_cnt_r - 1'b1;                                 // R17
      pin_n_r <= pin_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // analog trim, power policy, reset threshold
  // ----------------------------------------------------------------
  assign cx_half_pf = {~analog_trim_cfg_r[rtc_cfg_pkg::AT_TOP_BIT], 5'b0} +
                      {2'b0, analog_trim_cfg_r[4:0]} +
                      rtc_cfg_pkg::CX_BASE_HALF_PF;                        // R8
  assign bus_enable = ~(on_backup & bus_off_in_backup);                    // R12
  assign supply_switch_policy = power_switch_cfg_r[rtc_cfg_pkg::BSW_BIT];  // R13

  // decode of the threshold field, unlisted codes keep the top level
  always_comb
  begin
    unique case (power_switch_cfg_r[2:0])
      3'h1:    reset_threshold_mv = rtc_cfg_pkg::VRST_4380;  // R14
      3'h2:    reset_threshold_mv = rtc_cfg_pkg::VRST_3090;  // R14
      3'h3:    reset_threshold_mv = rtc_cfg_pkg::VRST_2920;  // R14
      3'h4:    reset_threshold_mv = rtc_cfg_pkg::VRST_2630;  // R14
      default: reset_threshold_mv = rtc_cfg_pkg::VRST_4640;  // R14
    endcase
  end

  assign reg_rdata            = reg_rdata_r;
  assign alarm0_flag          = alarm0_flag_r;
  assign alarm1_flag          = alarm1_flag_r;
  assign alarm_or_clock_out_n = pin_n_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  guard_drop_a: assert property (ee_wr_req && ee_blocked |-> !ee_wr_go)  // R1
    else $error("guarded eeprom write passed");
  guard_full_a: assert property (write_guard_field == 3'h7 |-> !ee_wr_go)  // R2
    else $error("full array guard let a write through");
  clkout_quiet_a: assert property (clk_out_sel == rtc_cfg_pkg::CLKSEL_1HZ  // R6 R7
      |=> pin_n_r == $past(div_r[rtc_cfg_pkg::DIV_1HZ_BIT]))
    else $error("1Hz output not following divider");
  no_enable_a: assert property (!any_irq_on && alarm_route |=> pin_n_r)  // R3
    else $error("pin low with no alarm enable");
  pulse_len_a: assert property (pulse_start ##1 pulse_keep [*8] |->  // R17 R4
      !pin_n_r)
    else $error("pulsed alarm too short");
  flag_set_a: assert property (alarm0_match |=> alarm0_flag_r)  // R15
    else $error("alarm 0 flag not set by match");
  flag_clear_a: assert property (sr_read && !alarm1_match |=> !alarm1_flag_r)  // R16
    else $error("status read did not clear alarm 1 flag");
  single_hold_a: assert property (single_low && !sr_read && alarm_route  // R16 R5
      |=> !pin_n_r)
    else $error("single event pin released early");
  bus_off_a: assert property (on_backup && bus_off_in_backup |-> !bus_enable)  // R12
    else $error("bus enabled in backup with bus-off set");
  trim_sign_a: assert property (dt_sign && dt_mag != 6'd0 |-> trim_ppm < 0)  // R10 R11
    else $error("negative trim sign not applied");

  match_pulse_c: cover property (pulse_start ##1 !pin_n_r);
  single_event_c: cover property (single_low ##1 sr_read);
  guard_drop_c: cover property (ee_wr_req && !ee_wr_go);
  trim_add_c: cover property (sec_nxt && acc_ovf);

endmodule

`default_nettype wire

//--- src/rtc_cfg_pkg.sv
/*
  constants for the rtc configuration, alarm output and trim block:
  register addresses, field positions, reset values, decode tables and
  timing figures. assumes a 250 MHz core clock and a 32.768 kHz
  oscillator level presented synchronously to that clock.
*/
`default_nettype none

package rtc_cfg_pkg;

  // ----------------------------------------------------------------
  // register addresses on the serial register port
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GUARD   = 8'h10;  // write_guard_cfg
  localparam logic [7:0] ADDR_IRQ     = 8'h11;  // alarm_irq_clkout_cfg
  localparam logic [7:0] ADDR_ATRIM   = 8'h12;  // analog_trim_cfg
  localparam logic [7:0] ADDR_DTRIM   = 8'h13;  // digital_trim_cfg
  localparam logic [7:0] ADDR_PWR     = 8'h14;  // power_switch_cfg
  localparam logic [7:0] ADDR_STATUS  = 8'h3f;  // status, alarm flags

  // ----------------------------------------------------------------
  // writable bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_GUARD   = 8'hf8;
  localparam logic [7:0] MASK_IRQ     = 8'hf8;
  localparam logic [7:0] MASK_ATRIM   = 8'h3f;
  localparam logic [7:0] MASK_DTRIM   = 8'h07;
  localparam logic [7:0] MASK_PWR     = 8'hc7;
  localparam logic [7:0] RST_GUARD    = 8'h18;
  localparam logic [7:0] RST_IRQ      = 8'h00;
  localparam logic [7:0] RST_ATRIM    = 8'h00;
  localparam logic [7:0] RST_DTRIM    = 8'h00;
  localparam logic [7:0] RST_PWR      = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GUARD_LSB   = 5;   // write_guard_field [7:5]
  localparam int IM_BIT      = 7;   // pulsed_alarm_select
  localparam int ALARM1_IRQ_ON_BIT    = 6;   // alarm1_irq_on
  localparam int ALARM0_IRQ_ON_BIT    = 5;   // alarm0_irq_on
  localparam int FO_LSB      = 3;   // clk_out_sel_hi/lo [4:3]
  localparam int BUS_OFF_IN_BACKUP_BIT    = 7;   // bus_off_in_backup
  localparam int BSW_BIT     = 6;   // supply_switch_policy
  localparam int SR_AL1_BIT  = 6;   // alarm1_flag in status
  localparam int SR_AL0_BIT  = 5;   // alarm0_flag in status
  localparam int DT_SIGN_BIT = 2;   // digital_trim_sign
  localparam int DT_10_BIT   = 1;   // digital_trim_10ppm
  localparam int DT_20_BIT   = 0;   // digital_trim_20ppm
  localparam int AT_TOP_BIT  = 5;   // inverted 16 pF weight

  // ----------------------------------------------------------------
  // write guard partitions, eeprom address bounds
  // ----------------------------------------------------------------
  localparam logic [8:0] EE_UPPER_Q   = 9'h180;
  localparam logic [8:0] EE_UPPER_H   = 9'h100;
  localparam logic [8:0] EE_FIRST_4P  = 9'h03f;
  localparam logic [8:0] EE_FIRST_8P  = 9'h07f;
  localparam logic [8:0] EE_FIRST_16P = 9'h0ff;

  // ----------------------------------------------------------------
  // clock output selection codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CLKSEL_ALARM, CLKSEL_32K, CLKSEL_4096, CLKSEL_1HZ
  } clk_sel_t;
  localparam int DIV_4096_BIT = 2;    // 32768 / 8
  localparam int DIV_1HZ_BIT  = 14;   // 32768 / 32768
  localparam int DIV_W        = 15;

  // ----------------------------------------------------------------
  // trim figures
  // ----------------------------------------------------------------
  localparam logic [6:0] CX_BASE_HALF_PF = 7'd18;   // 9 pF in 0.5 pF
  localparam logic [5:0] PPM_STEP_10     = 6'd10;
  localparam logic [5:0] PPM_STEP_20     = 6'd20;
  localparam logic [20:0] OSC_HZ         = 21'd32768;
  localparam logic [20:0] PPM_DEN        = 21'd1000000;

  // ----------------------------------------------------------------
  // reset threshold decode, millivolts
  // ----------------------------------------------------------------
  localparam logic [12:0] VRST_4640 = 13'd4640;
  localparam logic [12:0] VRST_4380 = 13'd4380;
  localparam logic [12:0] VRST_3090 = 13'd3090;
  localparam logic [12:0] VRST_2920 = 13'd2920;
  localparam logic [12:0] VRST_2630 = 13'd2630;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 250;
  localparam int PULSE_NS      = 1000;   // pulsed alarm low time
  localparam int PULSE_CYC     = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_W       = 9;

endpackage

`default_nettype wire

//--- verification/rtc_cfg_alarm_trim_test.sv
/*
  self-checking bench for the configuration, alarm pin and trim block.
  assumes the host model drives the register port on falling edges.
*/
`default_nettype none

module rtc_cfg_alarm_trim_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, srst = 1'b1, ee_wr_req = 1'b1, osc_32k = 1'b1, on_backup = 1'b1;
  logic m0 = 1'b0, m1 = 1'b0, f0, f1, pin, go, tick, bus_en, pol, osc_seen = 1'b0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd;
  logic [8:0] ea = 9'h000;
  logic [6:0] cx;
  logic signed [5:0] ppm;
  logic [12:0] mv;
  logic [5:0] e;
  int num_errors = 0, total_checks = 0, n, rises = 0;
  logic [8:0] ads [9] = '{9'h03f, 9'h040, 9'h07f, 9'h080, 9'h0ff, 9'h100, 9'h17f, 9'h180, 9'h1ff};
  int vt [5] = '{4640, 4380, 3090, 2920, 2630};

  always #2 clock = ~clock;

  // fast oscillator stand-in: one full period every two clocks
  always @(negedge clock) osc_32k <= ~osc_32k;

  // oscillator rising edges seen since reset release
  always @(posedge clock)
  begin
    osc_seen <= osc_32k;
    if (!srst && osc_32k && !osc_seen) rises <= rises + 1;
  end

  rtc_cfg_alarm_trim u_rtc_cfg_alarm_trim (.clock(clock), .srst(srst), .reg_addr(addr),
    .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata), .ee_addr(ea),
    .ee_wr_req(ee_wr_req), .ee_wr_go(go), .alarm0_match(m0), .alarm1_match(m1),
    .alarm0_flag(f0), .alarm1_flag(f1), .osc_32k(osc_32k), .alarm_or_clock_out_n(pin),
    .cx_half_pf(cx), .trim_ppm(ppm), .sec_tick(tick), .on_backup(on_backup),
    .bus_enable(bus_en), .supply_switch_policy(pol), .reset_threshold_mv(mv));
  rtc_host_model u_rtc_host_model (.clock(clock), .reg_rdata(rdata), .reg_addr(addr),
    .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd));

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic summarize;
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one-cycle match pulse, then let flag and pin settle
  task automatic hit(input logic which);
    @(negedge clock);
    if (which) m1 = 1'b1; else m0 = 1'b1;
    @(negedge clock);
    {m1, m0} = 2'b00;
    repeat (3) @(negedge clock);
  endtask

  initial
  begin
    repeat (12) @(negedge clock);
    srst = 1'b0;
    u_rtc_host_model.rd(8'h10, d); chk("guard reset", d, 8'h18);
    u_rtc_host_model.wr(8'h11, 8'hff);
    u_rtc_host_model.rd(8'h11, d); chk("irq mask", d, 8'hf8);
    u_rtc_host_model.rd(8'h20, d); chk("unmapped", d, 8'h00);
    // guard partitions
    for (int g = 0; g < 8; g++)
    begin
      u_rtc_host_model.wr(8'h10, 8'(g << 5));
      foreach (ads[i])
      begin
        @(negedge clock);
        ea = ads[i];
        #1;
        e[0] = (g == 1) ? ea >= 9'h180 : (g == 2) ? ea >= 9'h100 : (g == 3 || g == 7) ? 1'b1 :
               (g == 4) ? ea <= 9'h03f : (g == 5) ? ea <= 9'h07f : (g == 6) ? ea <= 9'h0ff : 1'b0;
        chk("ee go", go, !e[0]);
      end
    end
    u_rtc_host_model.wr(8'h10, 8'h00);
    ee_wr_req = 1'b0;
    #1;
    chk("no request", go, 1'b0);
    // trims
    for (int t = 0; t < 8; t++)
    begin
      u_rtc_host_model.wr(8'h13, 8'(t));
      e = 6'(10 * t[1] + 20 * t[0]);
      chk("trim", 16'(ppm), 16'(t[2] ? -e : e));
      u_rtc_host_model.wr(8'h12, 8'(t * 9));
      e = 6'(t * 9);
      chk("cap", cx, (e[5] ? 16'd0 : 16'd32) + e[4:0] + 16'd18);
    end
    // power policy and thresholds
    for (int v = 0; v < 5; v++)
    begin
      u_rtc_host_model.wr(8'h14, {v[0], ~v[0], 3'b000, 3'(v)});
      chk("vrst", mv, 16'(vt[v]));
      chk("policy", pol, !v[0]);
      chk("bus", bus_en, !v[0]);
      on_backup = 1'b0;
      @(negedge clock);
      chk("bus main", bus_en, 1'b1);
      on_backup = 1'b1;
    end
    // single event alarm
    u_rtc_host_model.wr(8'h11, 8'h20);
    hit(1'b0);
    repeat (20) @(negedge clock);
    chk("single pin", pin, 1'b0);
    u_rtc_host_model.rd(8'h3f, d); chk("status", d, 8'h20);
    repeat (2) @(negedge clock);
    chk("pin free", pin, 1'b1);
    // clock output suppresses, flags still set
    u_rtc_host_model.wr(8'h11, 8'h68);
    hit(1'b0);
    d[0] = pin;
    @(negedge clock);
    chk("suppress", pin, !d[0]);
    chk("flag0", f0, 1'b1);
    // 4096 Hz selection: pin toggles every eight clocks here
    u_rtc_host_model.wr(8'h11, 8'h10);
    @(negedge clock);
    n = 0;
    repeat (16)
    begin
      d[0] = pin;
      @(negedge clock);
      n = n + (pin != d[0]);
    end
    chk("4096 out", 16'(n), 16'd2);
    u_rtc_host_model.wr(8'h11, 8'h00);
    hit(1'b1);
    chk("no enable", pin, 1'b1);
    chk("flag1", f1, 1'b1);
    u_rtc_host_model.rd(8'h3f, d); chk("flags", d, 8'h60);
    // pulsed alarm, twice
    u_rtc_host_model.wr(8'h11, 8'he0);
    for (int k = 0; k < 2; k++)
    begin
      hit(k[0]);
      n = 0;
      while (pin === 1'b0 && n < 400)
      begin
        @(negedge clock);
        n++;
      end
      if (n == 400) num_errors++;
      chk("pulse", 16'(n + 2), 16'(rtc_cfg_pkg::PULSE_CYC));
    end
    // 1 Hz selection while the first trimmed second completes
    u_rtc_host_model.wr(8'h11, 8'h18);
    n = 0;
    while (tick !== 1'b1 && n < 70000)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 70000) num_errors++;
    chk("second", 16'(rises), 16'd32768);
    summarize();
  end
endmodule

`default_nettype wire

//--- verification/rtc_host_model.sv
/*
  host side of the register port: byte writes and byte reads.
  assumes a free running clock; drives only on its falling edge.
*/
`default_nettype none

module rtc_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // one byte write, strobe held across one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr    = 1'b0;
    reg_wdata = ~d;  // released data shows no stale byte
  endtask

  // one byte read, data taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clock);
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask
endmodule

`default_nettype wire
